// ==== logic/iec_consts.svh ====
// constants for the bus error, reset and initialisation block
`ifndef IEC_CONSTS_SVH
`define IEC_CONSTS_SVH
// ----------------------------------------
// status codes
// ----------------------------------------
`define IEC_ST_IDLE 8'hf8
`define IEC_ST_BUSERR 8'h00
`define IEC_ST_SDALOW 8'h70
// ----------------------------------------
// timing
// ----------------------------------------
`define IEC_CLK_NS 50
`define IEC_INIT_US 550
`define IEC_INIT_CYC ((`IEC_INIT_US * 1000) / `IEC_CLK_NS)
`define IEC_HALF_NS 200
`define IEC_HALF_CYC 3'((`IEC_HALF_NS) / (`IEC_CLK_NS))
`define IEC_RSTW_NS 200
`define IEC_RSTW_CYC 4'((`IEC_RSTW_NS + `IEC_CLK_NS - 1) / `IEC_CLK_NS)
`define IEC_RCV_PULSES 4'h9
`define IEC_ACK_BIT 4'h8
// ----------------------------------------
// software reset byte sequence and write fifo size
// ----------------------------------------
`define IEC_SWRST_B0 8'ha5
`define IEC_SWRST_B1 8'h5a
`define IEC_FIFO_DEPTH 16
`define IEC_FIFO_W 9
`endif

// ==== logic/iec_pkg.sv ====
// types for the bus error, reset and initialisation block
package iec_pkg;
    typedef struct packed {
        logic ctrl;
        logic [7:0] data;
    } iec_wr_s;
    typedef enum logic [3:0] {
        M_IDLE = 4'h0,
        M_FREE = 4'h1,
        M_START = 4'h2,
        M_LOAD = 4'h3,
        M_LOW = 4'h4,
        M_HIGH = 4'h5,
        M_STOP = 4'h6,
        M_STOP2 = 4'h7,
        M_RCVL = 4'h8,
        M_RCVH = 4'h9,
        M_ERR = 4'ha
    } iec_mst_e;
endpackage : iec_pkg

// ==== logic/iec_top.sv ====
// bus error detection, power-up init, reset and i2c bit-level master for the controller
`timescale 1ns/1ns
`include "iec_consts.svh"

// ----------------------------------------
// write fifo
// ----------------------------------------
module iec_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset
    input wire logic clr, // sync flush
    input wire logic in_valid, // write valid
    output logic in_ready, // not full
    input wire logic [W-1:0] in_data, // write word
    output logic out_valid, // not empty
    input wire logic out_ready, // pop
    output logic [W-1:0] out_data // head word
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic push;
    logic pop;
    assign in_ready = (wp - rp) != (AW+1)'(D);
    assign out_valid = wp != rp;
    assign out_data = mem[rp[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else if (clr) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule : iec_fifo

// Functional notes
// - bus errors count only while master or addressed slave
// - start or stop inside a byte or acknowledge slot is a bus error; code does not flag one in the acknowledge clock
// - on bus error release both lines, set interrupt flag, status 00h
// - after power-on reset release the device runs an initialisation phase
// - oscillator bit goes 1, registers initialise, bit returns 0 (low power)
// - initialisation ends within 550 us of power-on release
// - oscillator bit readable: 1 busy initialising, 0 ready
// - reset pin held low long enough or software sequence restores defaults
// - master starts only after seeing the bus free
// - one bit per clock pulse; data stable while clock high
// - idle is both high; sda fall in scl high start, rise stop
// - eight bits then one acknowledge bit; master clocks it; bytes unlimited
// - receivers pull sda low through the acknowledge clock high; code drives the slave ack over the eighth clock
// - master receiver ends by not acknowledging; transmitter leaves sda high
// - after reset or stop report f8h with flag clear; errors need reset
// - sda held low: nine pulses, stop; still low gives 70h, flag, release; code gives 70h each time, reading sda while still driving it low
module iec_top #(
    parameter int INIT_CYC = `IEC_INIT_CYC
) (
    input wire logic mclk, // 20 MHz clock
    input wire logic rst_n, // power-on reset, active low
    input wire logic reset_pin_n, // external reset pin
    input wire logic scl_in, // scl line level
    input wire logic sda_in, // sda line level
    output logic scl_out, // scl drive value
    output logic scl_oe, // scl pulled low
    output logic sda_out, // sda drive value
    output logic sda_oe, // sda pulled low
    input wire logic wr_valid, // host write strobe
    output logic wr_ready, // fifo space
    input wire iec_pkg::iec_wr_s wr_word, // host write: data or control byte
    input wire logic master_go, // request a master transfer
    input wire logic slave_active, // addressed slave in progress
    input wire logic slave_rx, // addressed slave is receiving
    input wire logic si_clr, // host clears interrupt flag
    output logic [7:0] status_register, // status code
    output logic si_flag, // serial interrupt flag
    output logic osc_enable_init_bit, // control register oscillator bit
    output logic bus_busy, // bus seen busy
    output logic nack_seen // last byte not acknowledged
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] rp_s;
    logic scl_d;
    logic sda_d;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            rp_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            rp_s <= {rp_s[0], reset_pin_n};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    logic scl;
    logic sda;
    logic start_ev;
    logic stop_ev;
    logic scl_fall;
    assign scl = scl_s[1];
    assign sda = sda_s[1];
    assign start_ev = scl && scl_d && sda_d && !sda;
    assign stop_ev = scl && scl_d && !sda_d && sda;
    assign scl_fall = scl_d && !scl;

    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    logic [3:0] rpw;
    logic pin_rst;
    logic sw_rst;
    logic sw_arm;
    logic srst;
    assign srst = pin_rst || sw_rst;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rpw <= 4'h0;
            pin_rst <= 1'b0;
        end else if (rp_s[1]) begin
            rpw <= 4'h0;
            pin_rst <= 1'b0;
        end else begin
            if (rpw != `IEC_RSTW_CYC) begin
                rpw <= rpw + 4'h1;
            end
            pin_rst <= (rpw == `IEC_RSTW_CYC - 4'h1);
        end
    end

    // ----------------------------------------
    // power-up initialisation
    // ----------------------------------------
    logic [15:0] init_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osc_enable_init_bit <= 1'b1;
            init_cnt <= 16'h0;
        end else if (osc_enable_init_bit) begin
            init_cnt <= init_cnt + 16'h1;
            if (init_cnt == 16'(INIT_CYC - 1)) begin
                osc_enable_init_bit <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // write fifo and control byte decode
    // ----------------------------------------
    iec_pkg::iec_wr_s head;
    logic head_valid;
    logic head_pop;
    logic m_load;
    // writes are held back while initialising
    assign head_pop = head_valid && !osc_enable_init_bit
        && (head.ctrl || m_load);
    iec_fifo #(.W(`IEC_FIFO_W), .D(`IEC_FIFO_DEPTH)) u_fifo (
        .clk(mclk),
        .rst_n(rst_n),
        .clr(srst),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_word),
        .out_valid(head_valid),
        .out_ready(head_pop),
        .out_data(head)
    );
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_arm <= 1'b0;
            sw_rst <= 1'b0;
        end else begin
            sw_rst <= 1'b0;
            if (srst) begin
                sw_arm <= 1'b0;
            end else if (head_pop && head.ctrl) begin
                sw_arm <= head.data == `IEC_SWRST_B0;
                sw_rst <= sw_arm && head.data == `IEC_SWRST_B1;
            end
        end
    end

    // ----------------------------------------
    // frame tracking and bus error detection
    // ----------------------------------------
    iec_pkg::iec_mst_e mst;
    logic [3:0] fbit;
    logic involved;
    logic bus_err;
    assign involved = slave_active || (mst != iec_pkg::M_IDLE && mst != iec_pkg::M_FREE
        && mst != iec_pkg::M_ERR);
    // start and stop are legal only before the first falling clock after a start, in each acknowledge clock, and while the bus is free after a stop
    assign bus_err = involved && (start_ev || stop_ev) && fbit != 4'h0;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fbit <= 4'h0;
            bus_busy <= 1'b0;
        end else if (srst || start_ev || stop_ev) begin
            fbit <= 4'h0;
            bus_busy <= start_ev;
        end else if (scl_fall && bus_busy) begin
            fbit <= (fbit == `IEC_ACK_BIT) ? 4'h0 : fbit + 4'h1;
        end
    end

    // ----------------------------------------
    // status code and interrupt flag
    // ----------------------------------------
    logic rcv_fail;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_register <= `IEC_ST_IDLE;
            si_flag <= 1'b0;
        end else if (srst) begin
            status_register <= `IEC_ST_IDLE;
            si_flag <= 1'b0;
        end else if (bus_err && mst != iec_pkg::M_ERR) begin
            status_register <= `IEC_ST_BUSERR;
            si_flag <= 1'b1;
        end else if (rcv_fail) begin
            status_register <= `IEC_ST_SDALOW;
            si_flag <= 1'b1;
        end else if (si_clr && status_register == `IEC_ST_IDLE) begin
            // error codes keep the flag until a reset
            si_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // master bit engine
    // ----------------------------------------
    logic [2:0] tcnt;
    logic tick;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic [3:0] pulses;
    logic rcv_mode;
    logic go_pend;
    logic m_scl_low;
    logic m_sda_low;
    assign tick = tcnt == `IEC_HALF_CYC - 3'h1;
    assign m_load = mst == iec_pkg::M_LOAD && !head.ctrl;
    assign rcv_fail = mst == iec_pkg::M_STOP2 && tick && rcv_mode && !sda;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tcnt <= 3'h0;
        end else if (tick || mst == iec_pkg::M_IDLE || mst == iec_pkg::M_FREE) begin
            tcnt <= 3'h0;
        end else if (mst != iec_pkg::M_HIGH && mst != iec_pkg::M_RCVH && mst != iec_pkg::M_STOP2 || scl) begin
            tcnt <= tcnt + 3'h1; // high phase waits for a stretched clock
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            go_pend <= 1'b0;
        end else if (srst) begin
            go_pend <= 1'b0;
        end else if (master_go) begin
            go_pend <= 1'b1;
        end else if (mst == iec_pkg::M_START) begin
            go_pend <= 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mst <= iec_pkg::M_IDLE;
            m_scl_low <= 1'b0;
            m_sda_low <= 1'b0;
            shreg <= 8'h0;
            bitn <= 4'h0;
            pulses <= 4'h0;
            rcv_mode <= 1'b0;
            nack_seen <= 1'b0;
        end else if (srst) begin
            mst <= iec_pkg::M_IDLE;
            m_scl_low <= 1'b0;
            m_sda_low <= 1'b0;
            rcv_mode <= 1'b0;
            nack_seen <= 1'b0;
        end else if (bus_err || rcv_fail) begin
            mst <= iec_pkg::M_ERR;
            m_scl_low <= 1'b0;
            m_sda_low <= 1'b0;
        end else begin
            case (mst)
                iec_pkg::M_IDLE: begin
                    if (go_pend && !osc_enable_init_bit && status_register == `IEC_ST_IDLE) begin
                        mst <= iec_pkg::M_FREE;
                    end
                end
                iec_pkg::M_FREE: begin
                    if (scl && !sda && !bus_busy) begin
                        mst <= iec_pkg::M_RCVL;
                        rcv_mode <= 1'b1;
                        pulses <= 4'h0;
                    end else if (scl && sda && !bus_busy) begin
                        mst <= iec_pkg::M_START;
                        m_sda_low <= 1'b1;
                    end
                end
                iec_pkg::M_START: begin
                    if (tick) begin
                        m_scl_low <= 1'b1;
                        mst <= iec_pkg::M_LOAD;
                    end
                end
                iec_pkg::M_LOAD: begin
                    bitn <= 4'h0;
                    if (head_valid && !head.ctrl && !osc_enable_init_bit) begin
                        shreg <= head.data;
                        mst <= iec_pkg::M_LOW;
                    end else if (!head_valid) begin
                        mst <= iec_pkg::M_STOP;
                        m_sda_low <= 1'b1;
                    end
                end
                iec_pkg::M_LOW: begin
                    // sda changes only while the clock is held low
                    m_sda_low <= (bitn != `IEC_ACK_BIT) && !shreg[7];
                    if (tick) begin
                        m_scl_low <= 1'b0;
                        mst <= iec_pkg::M_HIGH;
                    end
                end
                iec_pkg::M_HIGH: begin
                    if (tick) begin
                        m_scl_low <= 1'b1;
                        shreg <= {shreg[6:0], 1'b0};
                        bitn <= bitn + 4'h1;
                        mst <= iec_pkg::M_LOW;
                        if (bitn == `IEC_ACK_BIT) begin
                            nack_seen <= sda;
                            mst <= sda ? iec_pkg::M_STOP : iec_pkg::M_LOAD;
                            m_sda_low <= sda;
                        end
                    end
                end
                iec_pkg::M_STOP: begin
                    m_sda_low <= 1'b1;
                    if (tick) begin
                        m_scl_low <= 1'b0;
                        mst <= iec_pkg::M_STOP2;
                    end
                end
                iec_pkg::M_STOP2: begin
                    if (tick) begin
                        m_sda_low <= 1'b0;
                        rcv_mode <= 1'b0;
                        mst <= rcv_mode ? iec_pkg::M_FREE : iec_pkg::M_IDLE;
                    end
                end
                iec_pkg::M_RCVL: begin
                    m_scl_low <= 1'b1;
                    if (tick) begin
                        m_scl_low <= 1'b0;
                        pulses <= pulses + 4'h1;
                        mst <= iec_pkg::M_RCVH;
                    end
                end
                iec_pkg::M_RCVH: begin
                    if (tick) begin
                        m_scl_low <= 1'b1;
                        mst <= (pulses == `IEC_RCV_PULSES) ? iec_pkg::M_STOP : iec_pkg::M_RCVL;
                    end
                end
                iec_pkg::M_ERR: begin
                    m_scl_low <= 1'b0;
                    m_sda_low <= 1'b0;
                end
                default: begin
                    mst <= iec_pkg::M_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // slave receiver acknowledge and pin drivers
    // ----------------------------------------
    logic s_ack;
    // ack slot spans the eighth clock, from eighth fall to ninth fall counting the start fall
    assign s_ack = slave_active && slave_rx && fbit == `IEC_ACK_BIT;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= m_scl_low && !bus_err && !rcv_fail;
            sda_oe <= (m_sda_low || s_ack) && !bus_err && !rcv_fail && mst != iec_pkg::M_ERR;
        end
    end
endmodule : iec_top

// ==== testbench/iec_top_assertions.sv ====
// assertion checker for the error, reset and init block
`timescale 1ns/1ns
`include "iec_consts.svh"
module iec_chk #(
    parameter int INIT_CYC = 50
) (
    input wire logic mclk, // clock
    input wire logic rst_n, // power-on reset
    input wire logic reset_pin_n, // reset pin
    input wire logic scl_in, // scl level
    input wire logic sda_in, // sda level
    input wire logic scl_oe, // scl pull
    input wire logic sda_oe, // sda pull
    input wire logic wr_valid, // host write
    input wire logic [7:0] status_register, // status code
    input wire logic si_flag, // interrupt flag
    input wire logic osc_enable_init_bit, // init bit
    input wire logic bus_busy // bus busy
);
    // --------
    // init length counter
    // --------
    int init_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt <= 0;
        end else if (osc_enable_init_bit && init_cnt < 100000) begin
            init_cnt <= init_cnt + 1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    idle_rst_a: assert property ($rose(rst_n) |-> status_register == `IEC_ST_IDLE && !si_flag && !scl_oe)
        else $error("not idle after reset");
    init_quiet_a: assert property (osc_enable_init_bit |-> !scl_oe && !sda_oe)
        else $error("lines driven during init");
    init_max_a: assert property (init_cnt <= INIT_CYC + 1)
        else $error("init too long");
    init_min_a: assert property ($fell(osc_enable_init_bit) |-> init_cnt >= INIT_CYC - 1)
        else $error("init too short");
    osc_stay_a: assert property (!osc_enable_init_bit |=> !osc_enable_init_bit)
        else $error("init bit set again");
    err_release_a: assert property (si_flag && status_register inside {`IEC_ST_BUSERR, `IEC_ST_SDALOW}
        |=> !scl_oe && !sda_oe)
        else $error("lines held in error");
    err_flag_a: assert property (status_register inside {`IEC_ST_BUSERR, `IEC_ST_SDALOW} |-> si_flag)
        else $error("error without flag");
    err_hold_a: assert property ((reset_pin_n && !wr_valid) [*8] ##0 status_register == `IEC_ST_BUSERR
        |=> status_register == `IEC_ST_BUSERR && si_flag)
        else $error("error left without reset");
    pin_reset_a: assert property (!reset_pin_n [*8] ##1 !reset_pin_n
        |-> status_register == `IEC_ST_IDLE && !si_flag)
        else $error("pin reset not applied");
    start_free_a: assert property ($rose(sda_oe) && !scl_oe |-> $past(scl_in) && $past(sda_in) && !bus_busy)
        else $error("start on busy bus");
    data_stable_a: assert property ($fell(scl_oe) |=> $stable(sda_oe) [*3])
        else $error("sda moved in clock high");
endmodule : iec_chk
bind iec_top iec_chk #(.INIT_CYC(INIT_CYC)) u_iec_chk (.mclk(mclk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .wr_valid(wr_valid),
    .status_register(status_register), .si_flag(si_flag), .osc_enable_init_bit(osc_enable_init_bit),
    .bus_busy(bus_busy));

// ==== testbench/iec_slave.sv ====
// far-side slave receiver model with acknowledge, stall and stuck-sda modes
`timescale 1ns/1ns
module iec_slave (
    input wire logic scl, // scl line level
    input wire logic sda, // sda line level
    input wire logic ack_en, // acknowledge bytes
    input wire logic stuck, // hold sda low
    input wire logic stretch, // stall scl after each fall
    output logic scl_low, // pull scl low
    output logic sda_low // pull sda low
);
    logic [7:0] got [$];
    logic [7:0] sh;
    logic [3:0] bitn;
    logic ack_drv;
    initial begin
        bitn = 4'hf;
        ack_drv = 1'b0;
        scl_low = 1'b0;
    end
    assign sda_low = stuck | ack_drv;
    always @(negedge sda) begin
        if (scl) begin
            bitn = 4'hf;
        end
    end
    always @(posedge scl) begin
        if (bitn == 4'h8) begin
            got.push_back(sh);
        end else begin
            sh = {sh[6:0], sda};
        end
    end
    always @(negedge scl) begin
        bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
        ack_drv = ack_en && bitn == 4'h8;
        if (stretch) begin
            scl_low = 1'b1;
            #400 scl_low = 1'b0;
        end
    end
endmodule : iec_slave

// ==== testbench/iec_top_tb.sv ====
// self-checking bench for the error, reset and init block
`timescale 1ns/1ns
`include "iec_consts.svh"
module iec_top_tb;
    localparam int INIT = 50;
    logic mclk, rst_n, reset_pin_n, wr_valid, master_go, slave_active, si_clr;
    logic scl_out, sda_out, scl_oe, sda_oe, wr_ready, si_flag, osc, bus_busy, nack_seen;
    logic ack_en, stuck, stretch, s_scl, s_sda, i_scl, i_sda;
    logic [7:0] status;
    iec_pkg::iec_wr_s wr_word;
    int bad_count, num_checks, cyc, pulses;
    wire logic scl = ~(scl_oe | s_scl | i_scl);
    wire logic sda = ~(sda_oe | s_sda | i_sda);
    iec_top #(.INIT_CYC(INIT)) u_iec_top (.mclk(mclk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
        .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .master_go(master_go),
        .slave_active(slave_active), .slave_rx(1'b0), .si_clr(si_clr), .status_register(status),
        .si_flag(si_flag), .osc_enable_init_bit(osc), .bus_busy(bus_busy), .nack_seen(nack_seen));
    iec_slave u_iec_slave (.scl(scl), .sda(sda), .ack_en(ack_en), .stuck(stuck), .stretch(stretch),
        .scl_low(s_scl), .sda_low(s_sda));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    always @(posedge scl) pulses++;
    // --------
    // shared tasks
    // --------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic put(input logic c, input logic [7:0] d);
        @(negedge mclk);
        wr_valid = 1'b1;
        wr_word = {c, d};
        while (!wr_ready) @(negedge mclk);
        @(negedge mclk);
        wr_valid = 1'b0;
    endtask : put
    task automatic go();
        @(negedge mclk);
        master_go = 1'b1;
        @(negedge mclk);
        master_go = 1'b0;
    endtask : go
    task automatic go_and_wait();
        go();
        for (int i = 0; i < 200 && !bus_busy; i++) @(negedge mclk);
        for (int i = 0; i < 9000 && bus_busy; i++) @(negedge mclk);
        tick(4);
    endtask : go_and_wait
    task automatic ext_frame();
        i_sda = 1'b1;
        #200 i_scl = 1'b1;
        #200 i_scl = 1'b0;
        #200 i_scl = 1'b1;
        #200 i_scl = 1'b0;
        #200 i_sda = 1'b0;
        tick(8);
    endtask : ext_frame
    // --------
    // scenarios
    // --------
    task automatic t_init();
        tick(2);
        check(status, `IEC_ST_IDLE);
        check({7'h0, si_flag}, 8'h00);
        tick(INIT - 10);
        check({7'h0, osc}, 8'h01);
        tick(20);
        check({7'h0, osc}, 8'h00);
    endtask : t_init
    task automatic t_stream();
        stretch = 1'b1;
        for (int i = 0; i < 16; i++) put(1'b0, 8'(i * 17));
        check({7'h0, wr_ready}, 8'h00);
        go_and_wait();
        check(8'(u_iec_slave.got.size()), 8'h10);
        for (int i = 0; i < 16; i++) check(u_iec_slave.got[i], 8'(i * 17));
        check({6'h0, wr_ready, nack_seen}, 8'h02);
        check(status, `IEC_ST_IDLE);
        stretch = 1'b0;
    endtask : t_stream
    task automatic t_nack();
        ack_en = 1'b0;
        u_iec_slave.got.delete();
        put(1'b0, 8'h3c);
        go_and_wait();
        check({7'h0, nack_seen}, 8'h01);
        check(u_iec_slave.got[0], 8'h3c);
        check(status, `IEC_ST_IDLE);
        ack_en = 1'b1;
    endtask : t_nack
    task automatic t_bus_err();
        ext_frame();
        check(status, `IEC_ST_IDLE);
        slave_active = 1'b1;
        ext_frame();
        slave_active = 1'b0;
        check(status, `IEC_ST_BUSERR);
        check({6'h0, si_flag, scl_oe | sda_oe}, 8'h02);
        check({5'h0, bus_busy, scl_out, sda_out}, 8'h00);
        si_clr = 1'b1;
        tick(1);
        si_clr = 1'b0;
        tick(10);
        check({si_flag, status[6:0]}, 8'h80);
        reset_pin_n = 1'b0;
        tick(10);
        reset_pin_n = 1'b1;
        tick(4);
        check({si_flag, status[6:0]}, 8'h78);
    endtask : t_bus_err
    task automatic t_stuck();
        i_scl = 1'b1;
        tick(2);
        stuck = 1'b1;
        tick(2);
        i_scl = 1'b0;
        tick(4);
        pulses = 0;
        go();
        for (int i = 0; i < 3000 && !si_flag; i++) @(negedge mclk);
        tick(2);
        // nine clock pulses plus the release for stop
        check(8'(pulses), 8'h0a);
        check(status, `IEC_ST_SDALOW);
        check({7'h0, scl_oe | sda_oe}, 8'h00);
        stuck = 1'b0;
        put(1'b1, `IEC_SWRST_B0);
        put(1'b1, `IEC_SWRST_B1);
        tick(4);
        check({si_flag, status[6:0]}, 8'h78);
    endtask : t_stuck
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        rst_n = 1'b0;
        reset_pin_n = 1'b1;
        wr_valid = 1'b0;
        wr_word = '0;
        master_go = 1'b0;
        slave_active = 1'b0;
        si_clr = 1'b0;
        ack_en = 1'b1;
        stuck = 1'b0;
        stretch = 1'b0;
        i_scl = 1'b0;
        i_sda = 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        t_init();
        t_stream();
        t_nack();
        t_bus_err();
        t_stuck();
        tally_and_finish();
    end
endmodule : iec_top_tb
